//--- verilog/ucdc_pkg.sv
package ucdc_pkg;
    // =========================================================
    // line state codes
    localparam logic [1:0] LINE_SE0     = 2'h0;
    localparam logic [1:0] LINE_J       = 2'h1;
    localparam logic [1:0] LINE_K       = 2'h2;
    localparam logic [1:0] LINE_SE1     = 2'h3;
    // =========================================================
    // reset values
    localparam logic       RST_SWITCH   = 1'h0;
    localparam logic       RST_PULLUP   = 1'h0;
    localparam logic       RST_DETECT   = 1'h0;
    // =========================================================
    // mode bit pattern order: source, sink, contact, host, aux, pulldown
    localparam int         MODE_BITS    = 6;
    localparam logic [5:0] PAT_CONNECT  = 6'h09;
    localparam logic [5:0] PAT_CHARGER  = 6'h30;
    localparam logic [5:0] PAT_ENHANCED = 6'h34;
    localparam logic [5:0] PAT_USB      = 6'h00;
    localparam logic [5:0] PAT_CHP_SE0  = 6'h17;
    localparam logic [5:0] PAT_CHP_ATT  = 6'h37;
    localparam logic [5:0] PAT_CHP_USB  = 6'h07;
    // =========================================================
    // mode classification
    typedef enum logic [2:0] {
        UCDC_MODE_USB, UCDC_MODE_CONNECT, UCDC_MODE_CHARGER, UCDC_MODE_ENHANCED,
        UCDC_MODE_CHP_SE0, UCDC_MODE_CHP_ATT, UCDC_MODE_CHP_USB, UCDC_MODE_OTHER
    } ucdc_mode_t;
endpackage

//--- verilog/ucdc_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin levels
module ucdc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // =========================================================
    // synchroniser stages; first stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- verilog/ucdc_top.sv
`timescale 1ns/1ps
// Contract
// - detection stays live in low power
// - detect status reported via interrupt events
// - detect output only when line state 00
// - pull-ups off unless chip enabled
// - audio switches follow enables, reset off
// - receivers on in sync, off carkit
module ucdc_top (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // pins from the analog side
    input  wire logic       chip_enable_pin,
    input  wire logic [1:0] line_state_raw,
    input  wire logic       comparator_raw,
    // mode bits from the register array
    input  wire logic       data_voltage_source_on,
    input  wire logic       data_current_sink_on,
    input  wire logic       contact_sense_on,
    input  wire logic       host_charger_emulate_on,
    input  wire logic       auxiliary_mode_bit,
    input  wire logic       minus_line_pulldown_on,
    // other control bits
    input  wire logic       suspend_active_b,
    input  wire logic       carkit_mode,
    input  wire logic       weak_pullup_on_plus,
    input  wire logic       weak_pullup_on_minus,
    input  wire logic       left_speaker_switch_on,
    input  wire logic       right_speaker_switch_on,
    input  wire logic       microphone_switch_on,
    // status and analog enables
    output logic            data_line_voltage_seen,
    output logic            detect_change_event,
    output logic            detect_block_on,
    output logic [2:0]      mode_class,
    output logic            plus_pullup_drive,
    output logic            minus_pullup_drive,
    output logic            left_audio_pin_switch,
    output logic            right_audio_pin_switch,
    output logic            mic_switch,
    output logic            single_ended_rx_on
);
    // =========================================================
    // synchronised pin levels
    logic [3:0] pins_s;
    logic       cen_s;
    logic [1:0] line_s;
    logic       cmp_s;

    ucdc_sync #(.WIDTH(4)) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in ({chip_enable_pin, line_state_raw, comparator_raw}),
        .sync_out (pins_s)
    );

    assign cen_s  = pins_s[3];
    assign line_s = pins_s[2:1];
    assign cmp_s  = pins_s[0];

    // =========================================================
    // mode pattern decode, feeds the mode_class status only
    function automatic ucdc_pkg::ucdc_mode_t ucdc_classify(input logic [5:0] p);
        if (p == ucdc_pkg::PAT_USB)           ucdc_classify = ucdc_pkg::UCDC_MODE_USB;
        else if (p == ucdc_pkg::PAT_CONNECT)  ucdc_classify = ucdc_pkg::UCDC_MODE_CONNECT;
        else if (p == ucdc_pkg::PAT_CHARGER)  ucdc_classify = ucdc_pkg::UCDC_MODE_CHARGER;
        else if (p == ucdc_pkg::PAT_ENHANCED) ucdc_classify = ucdc_pkg::UCDC_MODE_ENHANCED;
        else if (p == ucdc_pkg::PAT_CHP_SE0)  ucdc_classify = ucdc_pkg::UCDC_MODE_CHP_SE0;
        else if (p == ucdc_pkg::PAT_CHP_ATT)  ucdc_classify = ucdc_pkg::UCDC_MODE_CHP_ATT;
        else if (p == ucdc_pkg::PAT_CHP_USB)  ucdc_classify = ucdc_pkg::UCDC_MODE_CHP_USB;
        else                                  ucdc_classify = ucdc_pkg::UCDC_MODE_OTHER;
    endfunction

    // =========================================================
    // combinational next values
    logic [5:0]           mode_bits;
    ucdc_pkg::ucdc_mode_t mode_now;
    logic                 detect_d;
    logic                 audio_ok;

    assign mode_bits = {data_voltage_source_on, data_current_sink_on, contact_sense_on,
                        host_charger_emulate_on, auxiliary_mode_bit, minus_line_pulldown_on};
    assign mode_now  = ucdc_classify(mode_bits);
    // suspend state is deliberately not a term here: detection runs in low power
    assign detect_d  = cen_s && (line_s == ucdc_pkg::LINE_SE0) && cmp_s;
    // carkit entry blocks audio? no: audio lives in carkit, only chip enable gates it
    assign audio_ok  = cen_s;

    // =========================================================
    // status flops; event pulses on any change of detect, in any mode
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_line_voltage_seen <= ucdc_pkg::RST_DETECT;
            detect_change_event    <= ucdc_pkg::RST_DETECT;
            detect_block_on        <= ucdc_pkg::RST_DETECT;
            mode_class             <= ucdc_pkg::UCDC_MODE_USB;
        end else begin
            data_line_voltage_seen <= detect_d;
            detect_change_event    <= detect_d ^ data_line_voltage_seen;
            detect_block_on        <= cen_s;
            mode_class             <= mode_now;
        end
    end

    // =========================================================
    // pull-ups, audio switches and receivers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            plus_pullup_drive      <= ucdc_pkg::RST_PULLUP;
            minus_pullup_drive     <= ucdc_pkg::RST_PULLUP;
            left_audio_pin_switch  <= ucdc_pkg::RST_SWITCH;
            right_audio_pin_switch <= ucdc_pkg::RST_SWITCH;
            mic_switch             <= ucdc_pkg::RST_SWITCH;
            single_ended_rx_on     <= 1'h0;
        end else begin
            plus_pullup_drive      <= cen_s & weak_pullup_on_plus;
            minus_pullup_drive     <= cen_s & weak_pullup_on_minus;
            left_audio_pin_switch  <= audio_ok & left_speaker_switch_on;
            right_audio_pin_switch <= audio_ok & right_speaker_switch_on;
            mic_switch             <= audio_ok & microphone_switch_on;
            single_ended_rx_on     <= ~carkit_mode & suspend_active_b;
        end
    end

    // =========================================================
    // checks
    property p_detect_gate;
        @(posedge core_clk) disable iff (!rst_b)
        data_line_voltage_seen |-> $past(line_s == ucdc_pkg::LINE_SE0) && $past(cen_s);
    endproperty
    a_detect_gate: assert property (p_detect_gate) else $error("detect seen outside se0");

    property p_detect_lowpower;
        @(posedge core_clk) disable iff (!rst_b)
        (!suspend_active_b && cen_s && cmp_s && line_s == ucdc_pkg::LINE_SE0) |=> data_line_voltage_seen;
    endproperty
    a_detect_lowpower: assert property (p_detect_lowpower) else $error("detect lost in low power");

    property p_event;
        @(posedge core_clk) disable iff (!rst_b)
        $changed(data_line_voltage_seen) |-> detect_change_event;
    endproperty
    a_event: assert property (p_event) else $error("no event on detect change");

    property p_pullup_off;
        @(posedge core_clk) disable iff (!rst_b)
        !cen_s |=> !plus_pullup_drive && !minus_pullup_drive;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up on without chip enable");

    property p_pullup_follow;
        @(posedge core_clk) disable iff (!rst_b)
        cen_s |=> plus_pullup_drive == $past(weak_pullup_on_plus);
    endproperty
    a_pullup_follow: assert property (p_pullup_follow) else $error("plus pull-up not following");

    property p_audio_off;
        @(posedge core_clk) disable iff (!rst_b)
        !cen_s |=> !left_audio_pin_switch && !right_audio_pin_switch && !mic_switch;
    endproperty
    a_audio_off: assert property (p_audio_off) else $error("audio switch on without chip enable");

    property p_audio_follow;
        @(posedge core_clk) disable iff (!rst_b)
        (cen_s && microphone_switch_on) |=> mic_switch;
    endproperty
    a_audio_follow: assert property (p_audio_follow) else $error("mic switch not on");

    property p_rx_carkit;
        @(posedge core_clk) disable iff (!rst_b)
        carkit_mode |=> !single_ended_rx_on;
    endproperty
    a_rx_carkit: assert property (p_rx_carkit) else $error("receivers on in carkit");

    property p_block_on;
        @(posedge core_clk) disable iff (!rst_b)
        !detect_block_on |-> !data_line_voltage_seen;
    endproperty
    a_block_on: assert property (p_block_on) else $error("detect while disabled");

    // event pulses only in the cycle the status level moves
    property p_event_only;
        @(posedge core_clk) disable iff (!rst_b)
        detect_change_event |-> $changed(data_line_voltage_seen);
    endproperty
    a_event_only: assert property (p_event_only) else $error("event without detect change");

    property p_pullup_follow_minus;
        @(posedge core_clk) disable iff (!rst_b)
        cen_s |=> minus_pullup_drive == $past(weak_pullup_on_minus);
    endproperty
    a_pullup_follow_minus: assert property (p_pullup_follow_minus) else $error("minus pull-up not following");

    property p_audio_stereo;
        @(posedge core_clk) disable iff (!rst_b)
        (cen_s && left_speaker_switch_on && right_speaker_switch_on) |=> left_audio_pin_switch && right_audio_pin_switch;
    endproperty
    a_audio_stereo: assert property (p_audio_stereo) else $error("speaker switches not on");

    property p_rx_sync;
        @(posedge core_clk) disable iff (!rst_b)
        (!carkit_mode && suspend_active_b) |=> single_ended_rx_on;
    endproperty
    a_rx_sync: assert property (p_rx_sync) else $error("receivers off in sync mode");

    c_detect:  cover property (@(posedge core_clk) disable iff (!rst_b) $rose(data_line_voltage_seen));
    c_connect: cover property (@(posedge core_clk) disable iff (!rst_b)
                               mode_class == ucdc_pkg::UCDC_MODE_CONNECT);
    c_audio:   cover property (@(posedge core_clk) disable iff (!rst_b) left_audio_pin_switch);
    c_enh:     cover property (@(posedge core_clk) disable iff (!rst_b)
                               mode_class == ucdc_pkg::UCDC_MODE_ENHANCED);
endmodule

//--- bench/ucdc_link_model.sv
`timescale 1ns/1ps
// ========
// link side: walks the classification flow, one step per poll
module ucdc_link_model #(
    parameter int TMO = 12
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // what the link sees
    input  wire logic       step,
    input  wire logic       host_port,
    input  wire logic       sess,
    input  wire logic [1:0] line,
    input  wire logic       det,
    // mode bits {source,sink,contact,host,aux,pulldown}
    output logic      [5:0] mode_bits
);
    logic [2:0] st_q;
    logic [2:0] st_d;
    logic [7:0] tmo_q;
    // next flow state; 5 and 6 end the run until the next poll
    always_comb begin
        st_d = st_q;
        case (st_q)
            3'h0: st_d = sess ? (host_port ? 3'h4 : 3'h1) : 3'h0;
            3'h1: st_d = (line == 2'h0 || line == 2'h3) ? 3'h2 :
                         (line == 2'h2 && tmo_q >= TMO) ? 3'h5 : 3'h1;
            3'h2: st_d = det ? 3'h3 : 3'h5;
            3'h3: st_d = 3'h5;
            3'h4: st_d = (line == 2'h1) ? 3'h6 : 3'h4;
            default: st_d = 3'h0;
        endcase
    end
    // timeout counts link clocks in connect detect, clears on a move
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q  <= 3'h0;
            tmo_q <= 8'h00;
        end else begin
            if (step) st_q <= st_d;
            tmo_q <= (st_q == 3'h1 && !(step && st_d != st_q)) ? tmo_q + {7'h00, tmo_q != 8'hFF} : 8'h00;
        end
    end
    // patterns; all clear while traffic runs in state 5, 07 in host port state 6
    assign mode_bits = (st_q == 3'h1) ? 6'h09 :
                       (st_q == 3'h2) ? 6'h30 :
                       (st_q == 3'h3) ? 6'h34 :
                       (st_q == 3'h4) ? (det ? 6'h37 : 6'h17) :
                       (st_q == 3'h6) ? 6'h07 : 6'h00;
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
// ========
// random pins and flow polls, checked against a queue
module testbench;
    typedef struct packed {
        logic [2:0] det;
        logic [2:0] blk;
        logic [2:0] pu;
        logic [2:0] au;
        logic [2:0] se;
        logic [2:0] cls;
    } ucdc_exp_t;
    logic core_clk, rst_b, cen, cmp, sus_b, carkit, pu_p, pu_m, left_audio_pin, right_audio_pin, mic;
    logic step, host_port, sess, det_prev;
    logic [1:0] line;
    logic [5:0] mb;
    logic det, ev, blk, pdp, pdm, swl, swr, swm, serx;
    logic [2:0] cls;
    logic [31:0] r;
    logic [5:0] pats [7] = '{6'h00, 6'h09, 6'h30, 6'h34, 6'h17, 6'h37, 6'h07};
    int seed = 32'h3859B667;
    int mismatches, n_compared, n_ev, exp_ev;
    ucdc_exp_t exp_q[$];
    ucdc_exp_t e;
    event chk;
    ucdc_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .chip_enable_pin(cen), .line_state_raw(line),
        .comparator_raw(cmp), .data_voltage_source_on(mb[5]), .data_current_sink_on(mb[4]),
        .contact_sense_on(mb[3]), .host_charger_emulate_on(mb[2]), .auxiliary_mode_bit(mb[1]),
        .minus_line_pulldown_on(mb[0]), .suspend_active_b(sus_b), .carkit_mode(carkit),
        .weak_pullup_on_plus(pu_p), .weak_pullup_on_minus(pu_m), .left_speaker_switch_on(left_audio_pin),
        .right_speaker_switch_on(right_audio_pin), .microphone_switch_on(mic), .data_line_voltage_seen(det),
        .detect_change_event(ev), .detect_block_on(blk), .mode_class(cls), .plus_pullup_drive(pdp),
        .minus_pullup_drive(pdm), .left_audio_pin_switch(swl), .right_audio_pin_switch(swr),
        .mic_switch(swm), .single_ended_rx_on(serx));
    ucdc_link_model i_link (.core_clk(core_clk), .rst_b(rst_b), .step(step), .host_port(host_port),
        .sess(sess), .line(line), .det(det), .mode_bits(mb));
    always #2.5 core_clk = ~core_clk;
    // pulses counted mid-cycle, clear of the launching edge
    always @(negedge core_clk) if (ev === 1'b1) n_ev++;
    // ========
    // compares
    task automatic cmp_out(logic [2:0] got, logic [2:0] want);
        n_compared++;
        if (got !== want) begin
            mismatches++;
            $display("unexpected at %0t: got %b want %b", $time, got, want);
        end
    endtask
    task automatic cmp_cnt(logic [31:0] got, logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            mismatches++;
            $display("unexpected at %0t: count %0d want %0d", $time, got, want);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // expectation from the present inputs
    task automatic note;
        ucdc_exp_t x;
        x.det = {2'h0, cen & (line == 2'h0) & cmp};
        x.blk = {2'h0, cen};
        x.pu  = {1'h0, pu_p & cen, pu_m & cen};
        x.au  = {left_audio_pin & cen, right_audio_pin & cen, mic & cen};
        x.se  = {2'h0, ~carkit & sus_b};
        x.cls = 3'h7;
        for (int i = 0; i < 7; i++) if (mb === pats[i]) x.cls = i[2:0];
        if (x.det[0] !== det_prev) exp_ev++;
        det_prev = x.det[0];
        exp_q.push_back(x);
        -> chk;
    endtask
    // watcher takes the oldest note
    always @(chk) begin
        e = exp_q.pop_front();
        cmp_out({2'h0, det}, e.det);
        cmp_out({2'h0, blk}, e.blk);
        cmp_out({1'h0, pdp, pdm}, e.pu);
        cmp_out({swl, swr, swm}, e.au);
        cmp_out({2'h0, serx}, e.se);
        cmp_out(cls, e.cls);
    end
    // ========
    // main sequence; suspend toggles freely to show detect stays live
    initial begin
        {core_clk, rst_b, cen, cmp, sus_b, carkit, pu_p, pu_m, left_audio_pin, right_audio_pin, mic} = 11'h000;
        {step, host_port, sess, line, det_prev} = 6'h00;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        note();
        for (int n = 0; n < 150; n++) begin
            @(posedge core_clk);
            r = $random(seed);
            cen <= r[0] | r[1];
            line <= r[4] ? 2'h0 : r[3:2];
            {cmp, sus_b, carkit, pu_p, pu_m, left_audio_pin, right_audio_pin, mic, host_port} <= r[13:5];
            sess <= r[14] | r[15];
            step <= 1'b1;
            @(posedge core_clk);
            step <= 1'b0;
            repeat (5) @(posedge core_clk);
            #1 note();
        end
        @(posedge core_clk);
        {left_audio_pin, right_audio_pin, mic} <= 3'h0;
        repeat (5) @(posedge core_clk);
        #1 note();
        cmp_cnt(n_ev, exp_ev);
        close_out();
    end
    initial begin
        #20000;
        mismatches++;
        close_out();
    end
endmodule
